// [cpu_dest_addr_defs.svh]
// constants for the destination and indirect operand address unit
//
// Functional notes
// - indexed destination: operand one plus index, accumulator source, two bytes
// - indexed arithmetic reads operand-plus-index location, writes result back, accumulator kept
// - direct immediate: operand one is target, operand two immediate, three bytes
// - indexed immediate: operand one plus index target, operand two immediate, three bytes
// - indexed and immediate results go to RAM or register space as the instruction selects
// - direct-to-direct only for plain move; RAM to RAM, three bytes
// - source indirect: fetch pointer, load pointed byte into accumulator, two bytes
// - destination indirect: fetch pointer, store accumulator at pointer, two bytes
// - both indirect forms write the incremented pointer back in the same instruction
// - indirect forms decode only for the indirect transfer opcode
`ifndef CPU_DEST_ADDR_DEFS_SVH
`define CPU_DEST_ADDR_DEFS_SVH

`define LEN_SHORT 2'h2
`define LEN_LONG 2'h3
`define LEN_NONE 2'h0
`define PTR_STEP 8'h01
`define BYTE_ZERO 8'h00
`define BYTE_MAX 8'hFF
`define SPACE_RAM 1'h0

`endif

// [cpu_dest_addr_pkg.sv]
// types shared by the destination and indirect operand address unit
`default_nettype none
package cpu_dest_addr_pkg;

  typedef enum logic [2:0] {
    dst_indexed_mode,
    dst_direct_imm_mode,
    dst_indexed_imm_mode,
    direct_direct_mode,
    src_indirect_inc_mode,
    dst_indirect_inc_mode
  } mode_type;

  typedef enum logic [2:0] {
    plain_transfer_op,
    indirect_transfer_op,
    add_op,
    sub_op,
    and_op,
    or_op,
    xor_op
  } op_type;

  typedef struct packed {
    mode_type mode;
    op_type op;
    logic regSpace;
    logic [7:0] operand1;
    logic [7:0] operand2;
  } request_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic regSpace;
    logic [7:0] addr;
    logic [7:0] wdata;
  } memcmd_type;

endpackage
`default_nettype wire

// [cpu_dest_addressing.sv]
// destination and indirect operand address generation and sequencing
`timescale 1ns/1ps
`default_nettype none
`include "cpu_dest_addr_defs.svh"

module cpu_dest_addressing (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  input wire cpu_dest_addr_pkg::request_type request,
  input wire logic [7:0] index,
  input wire logic [7:0] acc,
  input wire logic [7:0] memRdata,
  output var cpu_dest_addr_pkg::memcmd_type memCmd,
  output logic accWrite,
  output logic [7:0] accData,
  output logic [1:0] instLength,
  output logic done,
  output logic illegal,
  output logic busy
);

  // ****************************************
  // request decode
  // ****************************************
  typedef enum logic [3:0] {
    IDLE, OPND_RD, OPND_TAKE, PTR_RD, PTR_TAKE, IND_RD, IND_TAKE, DATA_WR, PTR_WR, FINISH
  } state_type;

  logic indexedMode;
  logic immMode;
  logic indirectMode;
  logic dirDirMode;
  logic arithOp;
  logic badCombo;
  logic [7:0] aluResult;

  assign indexedMode = (request.mode == cpu_dest_addr_pkg::dst_indexed_mode) ||
                       (request.mode == cpu_dest_addr_pkg::dst_indexed_imm_mode);
  assign immMode = (request.mode == cpu_dest_addr_pkg::dst_direct_imm_mode) ||
                   (request.mode == cpu_dest_addr_pkg::dst_indexed_imm_mode);
  assign indirectMode = (request.mode == cpu_dest_addr_pkg::src_indirect_inc_mode) ||
                        (request.mode == cpu_dest_addr_pkg::dst_indirect_inc_mode);
  assign dirDirMode = (request.mode == cpu_dest_addr_pkg::direct_direct_mode);
  assign arithOp = (request.op != cpu_dest_addr_pkg::plain_transfer_op) &&
                   (request.op != cpu_dest_addr_pkg::indirect_transfer_op);
  // direct-to-direct only with plain move; indirect modes only with indirect transfer
  assign badCombo = (dirDirMode && (request.op != cpu_dest_addr_pkg::plain_transfer_op)) ||
    (indirectMode != (request.op == cpu_dest_addr_pkg::indirect_transfer_op));

  // ****************************************
  // sequencer
  // ****************************************
  state_type state, next_state;
  cpu_dest_addr_pkg::request_type cur, next_cur;
  cpu_dest_addr_pkg::memcmd_type next_memCmd;
  logic [7:0] target, next_target;
  logic [7:0] srcData, next_srcData;
  logic [7:0] ptr, next_ptr;
  logic next_accWrite;
  logic [7:0] next_accData;
  logic [1:0] next_instLength;
  logic next_done;
  logic next_illegal;
  logic next_busy;

  // first source is the stored location, second is the immediate or accumulator
  always_comb begin
    case (cur.op)
      cpu_dest_addr_pkg::add_op: aluResult = 8'(memRdata + srcData);
      cpu_dest_addr_pkg::sub_op: aluResult = 8'(memRdata - srcData);
      cpu_dest_addr_pkg::and_op: aluResult = memRdata & srcData;
      cpu_dest_addr_pkg::or_op: aluResult = memRdata | srcData;
      cpu_dest_addr_pkg::xor_op: aluResult = memRdata ^ srcData;
      default: aluResult = srcData;
    endcase
  end

  always_comb begin
    next_state = state;
    next_cur = cur;
    next_target = target;
    next_srcData = srcData;
    next_ptr = ptr;
    next_memCmd = memCmd;
    next_memCmd.rd = 1'b0;
    next_memCmd.wr = 1'b0;
    next_accWrite = 1'b0;
    next_accData = accData;
    next_instLength = instLength;
    next_illegal = illegal;
    case (state)
      IDLE: begin
        if (start) begin
          next_cur = request;
          next_target = indexedMode ? 8'(request.operand1 + index) : request.operand1;
          next_srcData = immMode ? request.operand2 : acc;
          next_instLength = (immMode || dirDirMode) ? `LEN_LONG : `LEN_SHORT;
          next_illegal = badCombo;
          next_memCmd.regSpace = request.regSpace;
          if (badCombo) begin
            next_state = FINISH;
          end else if (indirectMode) begin
            next_memCmd.rd = 1'b1;
            next_memCmd.addr = request.operand1;
            next_memCmd.regSpace = `SPACE_RAM;
            next_state = PTR_RD;
          end else if (dirDirMode) begin
            next_memCmd.rd = 1'b1;
            next_memCmd.addr = request.operand2;
            next_memCmd.regSpace = `SPACE_RAM;
            next_state = OPND_RD;
          end else if (arithOp) begin
            next_memCmd.rd = 1'b1;
            next_memCmd.addr = next_target;
            next_state = OPND_RD;
          end else begin
            next_memCmd.wr = 1'b1;
            next_memCmd.addr = next_target;
            next_memCmd.wdata = next_srcData;
            next_state = DATA_WR;
          end
        end
      end
      OPND_RD: begin
        next_state = OPND_TAKE;
      end
      OPND_TAKE: begin
        next_memCmd.wr = 1'b1;
        next_memCmd.addr = target;
        next_memCmd.regSpace = (cur.mode == cpu_dest_addr_pkg::direct_direct_mode) ?
                               `SPACE_RAM : cur.regSpace;
        next_memCmd.wdata = (cur.mode == cpu_dest_addr_pkg::direct_direct_mode) ?
                            memRdata : aluResult;
        next_state = DATA_WR;
      end
      PTR_RD: begin
        next_state = PTR_TAKE;
      end
      PTR_TAKE: begin
        next_ptr = memRdata;
        next_memCmd.addr = memRdata;
        if (cur.mode == cpu_dest_addr_pkg::src_indirect_inc_mode) begin
          next_memCmd.rd = 1'b1;
          next_state = IND_RD;
        end else begin
          next_memCmd.wr = 1'b1;
          next_memCmd.wdata = srcData;
          next_state = DATA_WR;
        end
      end
      IND_RD: begin
        next_state = IND_TAKE;
      end
      IND_TAKE: begin
        next_accWrite = 1'b1;
        next_accData = memRdata;
        next_memCmd.wr = 1'b1;
        next_memCmd.addr = cur.operand1;
        next_memCmd.wdata = 8'(ptr + `PTR_STEP);
        next_state = PTR_WR;
      end
      DATA_WR: begin
        if (cur.mode == cpu_dest_addr_pkg::dst_indirect_inc_mode) begin
          next_memCmd.wr = 1'b1;
          next_memCmd.addr = cur.operand1;
          next_memCmd.wdata = 8'(ptr + `PTR_STEP);
          next_state = PTR_WR;
        end else begin
          next_state = FINISH;
        end
      end
      PTR_WR: begin
        next_state = FINISH;
      end
      FINISH: begin
        next_state = IDLE;
      end
      default: begin
        next_state = IDLE;
      end
    endcase
    next_done = (next_state == FINISH);
    next_busy = (next_state != IDLE);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state <= IDLE;
      cur <= '0;
      target <= `BYTE_ZERO;
      srcData <= `BYTE_ZERO;
      ptr <= `BYTE_ZERO;
      memCmd <= '0;
      accWrite <= 1'b0;
      accData <= `BYTE_ZERO;
      instLength <= `LEN_NONE;
      done <= 1'b0;
      illegal <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      target <= next_target;
      srcData <= next_srcData;
      ptr <= next_ptr;
      memCmd <= next_memCmd;
      accWrite <= next_accWrite;
      accData <= next_accData;
      instLength <= next_instLength;
      done <= next_done;
      illegal <= next_illegal;
      busy <= next_busy;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  logic taken;
  assign taken = start && (state == IDLE);

  sequence seqPtrFetch;
    memCmd.rd && (memCmd.regSpace == `SPACE_RAM) ##2 1'b1;
  endsequence

  sequence seqPtrBack;
    memCmd.wr && (memCmd.wdata == 8'(ptr + `PTR_STEP)) ##1 done;
  endsequence

  a_idx_target_addr: assert property (
    taken && (request.mode == cpu_dest_addr_pkg::dst_indexed_mode) &&
    (request.op == cpu_dest_addr_pkg::plain_transfer_op) |=>
    memCmd.wr && (memCmd.addr == 8'($past(request.operand1) + $past(index))) &&
    (memCmd.wdata == $past(acc)) && (instLength == `LEN_SHORT) ##1 done)
    else $error("indexed destination move wrong");

  a_arith_readback: assert property (
    taken && indexedMode && arithOp |=>
    memCmd.rd ##2 (memCmd.wr && (memCmd.addr == $past(memCmd.addr, 2)) && !accWrite))
    else $error("indexed arithmetic did not read then write same location");

  a_imm_direct: assert property (
    taken && (request.mode == cpu_dest_addr_pkg::dst_direct_imm_mode) &&
    (request.op == cpu_dest_addr_pkg::plain_transfer_op) |=>
    memCmd.wr && (memCmd.addr == $past(request.operand1)) &&
    (memCmd.wdata == $past(request.operand2)) && (instLength == `LEN_LONG))
    else $error("direct immediate form wrong");

  a_idx_imm_len: assert property (
    taken && (request.mode == cpu_dest_addr_pkg::dst_indexed_imm_mode) && !badCombo |=>
    (instLength == `LEN_LONG) && (target == 8'($past(request.operand1) + $past(index))))
    else $error("indexed immediate form wrong");

  a_space_select: assert property (
    memCmd.wr && (state == DATA_WR) && !busy == 1'b0 &&
    (cur.mode != cpu_dest_addr_pkg::direct_direct_mode) && !ptr_mode_f(cur.mode) |->
    memCmd.regSpace == cur.regSpace)
    else $error("result space differs from request");

  a_dirdir_only_move: assert property (
    taken && dirDirMode |=>
    (illegal == (cur.op != cpu_dest_addr_pkg::plain_transfer_op)) &&
    (illegal ? done : (memCmd.rd && (memCmd.addr == cur.operand2) &&
    (instLength == `LEN_LONG))))
    else $error("direct-to-direct decode wrong");

  a_src_indirect: assert property (
    taken && !badCombo && (request.mode == cpu_dest_addr_pkg::src_indirect_inc_mode) |=>
    seqPtrFetch ##0 memCmd.rd ##2 (accWrite && (accData == $past(memRdata))) ##0 seqPtrBack)
    else $error("source indirect sequence wrong");

  a_dst_indirect: assert property (
    taken && !badCombo && (request.mode == cpu_dest_addr_pkg::dst_indirect_inc_mode) |=>
    seqPtrFetch ##0 (memCmd.wr && (memCmd.wdata == $past(acc, 3)) &&
    (memCmd.addr == $past(memRdata))) ##1 seqPtrBack)
    else $error("destination indirect sequence wrong");

  a_ptr_writeback: assert property (
    (state == PTR_WR) |-> memCmd.wr && (memCmd.addr == cur.operand1) && ptr_mode_f(cur.mode))
    else $error("pointer write-back misplaced");

  a_ind_only_mvi: assert property (
    taken && (indirectMode != (request.op == cpu_dest_addr_pkg::indirect_transfer_op)) |=>
    illegal && done && !memCmd.rd && !memCmd.wr)
    else $error("indirect decode accepted wrong opcode");

  a_ptr_wrap: assert property (
    (state == PTR_WR) && (ptr == `BYTE_MAX) |-> memCmd.wdata == `BYTE_ZERO)
    else $error("pointer did not wrap");

  function automatic logic ptr_mode_f(input cpu_dest_addr_pkg::mode_type m);
    ptr_mode_f = (m == cpu_dest_addr_pkg::src_indirect_inc_mode) ||
                 (m == cpu_dest_addr_pkg::dst_indirect_inc_mode);
  endfunction

endmodule
`default_nettype wire

// [data_space_model.sv]
// behavioural data RAM and register space facing the operand address unit
`timescale 1ns/1ps
`default_nettype none
module data_space_model (
  input wire logic mclk,
  input wire cpu_dest_addr_pkg::memcmd_type memCmd,
  output logic [7:0] memRdata
);
  logic [7:0] ram [256];
  logic [7:0] regs [256];
  int hold;
  initial begin
    for (int i = 0; i < 256; i++) begin
      ram[i] = 8'(i) ^ 8'h5A;
      regs[i] = ~8'(i);
    end
    hold = 0;
    memRdata = 8'h00;
  end
  // read data stands two cycles, then toggles so stale bytes never pass
  always @(posedge mclk) begin
    if (memCmd.wr === 1'b1) begin
      if (memCmd.regSpace) regs[memCmd.addr] = memCmd.wdata;
      else ram[memCmd.addr] = memCmd.wdata;
    end
    if (memCmd.rd === 1'b1) begin
      memRdata <= memCmd.regSpace ? regs[memCmd.addr] : ram[memCmd.addr];
      hold <= 1;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end else begin
      memRdata <= ~memRdata;
    end
  end
endmodule
`default_nettype wire

// [tb_cpu_dest_and_indirect_addressing.sv]
// self-checking bench for the destination and indirect operand address unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin check_count++; \
  if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch at %0t: %s", $time, msg); end end
module tb_cpu_dest_and_indirect_addressing;
  logic mclk, rstn, start, accWrite, done, illegal, busy;
  cpu_dest_addr_pkg::request_type request;
  cpu_dest_addr_pkg::memcmd_type memCmd;
  logic [7:0] index, acc, memRdata, accData, lastAcc;
  logic [1:0] instLength;
  logic [7:0] bram [256];
  logic [7:0] breg [256];
  integer seed, n_mismatch, check_count, cycles, nAcc, expNAcc;

  cpu_dest_addressing dut (.mclk(mclk), .rstn(rstn), .start(start), .request(request),
    .index(index), .acc(acc), .memRdata(memRdata), .memCmd(memCmd), .accWrite(accWrite),
    .accData(accData), .instLength(instLength), .done(done), .illegal(illegal), .busy(busy));
  data_space_model mem (.mclk(mclk), .memCmd(memCmd), .memRdata(memRdata));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (accWrite === 1'b1) nAcc++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  // m: 0 indexed, 1 direct imm, 2 indexed imm, 3 direct-direct, 4 src ind, 5 dst ind
  // o: 0 plain, 1 indirect, 2 add, 3 sub, 4 and, 5 or, 6 xor
  task automatic run(input int m, input int o, input logic rs,
                     input logic [7:0] o1, input logic [7:0] o2,
                     input logic [7:0] x, input logic [7:0] a);
    logic [7:0] t, s, v, p;
    logic bad;
    int expN, n;
    bad = (m == 3) ? (o != 0) : (m >= 4) ? (o != 1) : (o == 1);
    t = (m == 0 || m == 2) ? o1 + x : o1;
    s = (m == 0) ? a : o2;
    expN = 1;
    if (!bad) begin
      case (m)
        3: begin
          bram[o1] = bram[o2];
          expN = 4;
        end
        4: begin
          p = bram[o1];
          lastAcc = bram[p];
          expNAcc++;
          bram[o1] = p + 8'h01;
          expN = 6;
        end
        5: begin
          p = bram[o1];
          bram[p] = a;
          bram[o1] = p + 8'h01;
          expN = 5;
        end
        default: begin
          v = rs ? breg[t] : bram[t];
          case (o)
            2: v = v + s;
            3: v = v - s;
            4: v = v & s;
            5: v = v | s;
            6: v = v ^ s;
            default: v = s;
          endcase
          if (rs) breg[t] = v;
          else bram[t] = v;
          expN = (o >= 2) ? 4 : 2;
        end
      endcase
    end
    @(posedge mclk);
    #2;
    start = 1'b1;
    request = '{mode: cpu_dest_addr_pkg::mode_type'(m), op: cpu_dest_addr_pkg::op_type'(o),
                regSpace: rs, operand1: o1, operand2: o2};
    index = x;
    acc = a;
    @(posedge mclk);
    #2;
    // start stays up while busy with junk operands, which must be ignored
    request = 23'($random(seed));
    index = 8'($random(seed));
    acc = 8'($random(seed));
    n = 1;
    while (done !== 1'b1 && n < 12) begin
      @(posedge mclk);
      #2;
      n++;
    end
    start = 1'b0;
    `CHK(n == expN, 1'b1, "done timing")
    `CHK(busy, 1'b1, "busy through done")
    `CHK(illegal, bad, "illegal flag")
    if (!bad) begin
      `CHK(instLength, (m >= 1 && m <= 3) ? 2'h3 : 2'h2, "length")
    end
    `CHK(accData, lastAcc, "accumulator data")
    `CHK(nAcc, expNAcc, "accumulator loads")
    for (int i = 0; i < 256; i++) begin
      `CHK(mem.ram[i], bram[i], "ram byte")
      `CHK(mem.regs[i], breg[i], "register byte")
    end
  endtask

  initial begin
    seed = 32'h928E;
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    nAcc = 0;
    expNAcc = 0;
    lastAcc = 8'h00;
    start = 1'b0;
    rstn = 1'b0;
    request = '0;
    index = 8'h00;
    acc = 8'h00;
    for (int i = 0; i < 256; i++) begin
      bram[i] = 8'(i) ^ 8'h5A;
      breg[i] = ~8'(i);
    end
    repeat (3) @(posedge mclk);
    #2;
    rstn = 1'b1;
    run(1, 0, 1'b0, 8'h10, 8'hFF, 8'h00, 8'h00);
    run(4, 1, 1'b0, 8'hA5, 8'h00, 8'h00, 8'h00);
    run(5, 1, 1'b0, 8'h10, 8'h00, 8'h00, 8'hC3);
    run(0, 2, 1'b1, 8'hF0, 8'h00, 8'h20, 8'h33);
    run(2, 3, 1'b0, 8'hFF, 8'h44, 8'hFF, 8'h00);
    for (int r = 0; r < 3; r++) begin
      for (int m = 0; m < 6; m++) begin
        for (int o = 0; o < 7; o++) begin
          run(m, o, 1'($random(seed)), 8'($random(seed)), 8'($random(seed)),
              8'($random(seed)), 8'($random(seed)));
        end
      end
    end
    close_out();
  end
endmodule
`default_nettype wire
